// *** hdl/gcm_pkg.sv ***
// shared types and constants for the glitchless clock multiplexer
package gcm_pkg;

    // width of the control bundle and of the synchroniser input
    localparam int unsigned CTRL_W = 6;
    localparam int unsigned CLK_W = 2;
    localparam int unsigned SYNC_W = CTRL_W + CLK_W;

    // bit positions inside the synchronised word
    localparam int unsigned POS_CLK_FIRST = 0;
    localparam int unsigned POS_CLK_SECOND = 1;
    localparam int unsigned POS_CTRL_LO = 2;

    localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;
    localparam logic DEF_INIT_OUT = 1'b0;
    localparam logic OFF = 1'b0;
    localparam logic ON = 1'b1;

    typedef struct packed {
        logic select_first;
        logic enable_first;
        logic select_second;
        logic enable_second;
        logic bypass_first;
        logic bypass_second;
    } gcm_ctrl_s;

    typedef struct packed {
        logic first;
        logic second;
    } gcm_pass_s;

    localparam gcm_pass_s PASS_RST = 2'h0;

    typedef enum logic [1:0] {
        MODE_FULL    = 2'b00,
        MODE_GATE    = 2'b01,
        MODE_ONE_SEL = 2'b10
    } gcm_mode_e;

    typedef enum logic [1:0] {
        SRC_PIN  = 2'b00,
        SRC_PREV = 2'b01,
        SRC_NEXT = 2'b10
    } gcm_src_e;

    typedef enum logic [1:0] {
        TGT_NONE   = 2'b00,
        TGT_FIRST  = 2'b01,
        TGT_SECOND = 2'b10
    } gcm_tgt_e;

    typedef enum logic [2:0] {
        ST_IDLE        = 3'b000,
        ST_RUN_FIRST   = 3'b001,
        ST_RUN_SECOND  = 3'b010,
        ST_WAIT_FIRST  = 3'b011,
        ST_WAIT_SECOND = 3'b100
    } gcm_state_e;

endpackage

// *** hdl/gcm_sync.sv ***
// two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module gcm_sync #(
    parameter int unsigned W = gcm_pkg::SYNC_W
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            meta_q <= W'(gcm_pkg::SYNC_RST);
            sync_q <= W'(gcm_pkg::SYNC_RST);
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// *** hdl/gcm_dual_clock_glitchless_mux.sv ***
// glitchless two-input clock multiplexer, oversampled on the system clock
//
// Contract
// - two unrelated input clocks, one output clock
// - select, enable, bypass line per input
// - full variant: input chosen only when select and enable
// - leave on old park edge, enter on new
// - idle level sets park level and edge
// - bypass leaves that input without waiting
// - first pair high, second not: first passes
// - gate and one-select variants from same core
// - neighbour cascade ports allow ring of eight
// - nothing chosen: output parked, no toggling
// - all four high: keep previous choice
// - boot pick; both boot picks rejected
`timescale 1ns/1ps
module gcm_dual_clock_glitchless_mux #(
    parameter gcm_pkg::gcm_mode_e MODE = gcm_pkg::MODE_FULL,
    parameter logic INIT_OUT = gcm_pkg::DEF_INIT_OUT,
    parameter logic BOOT_PICK_FIRST = gcm_pkg::OFF,
    parameter logic BOOT_PICK_SECOND = gcm_pkg::OFF,
    parameter gcm_pkg::gcm_src_e SRC_FIRST = gcm_pkg::SRC_PIN,
    parameter gcm_pkg::gcm_src_e SRC_SECOND = gcm_pkg::SRC_PIN
) (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic I_CLK_IN_FIRST,
    input wire logic I_CLK_IN_SECOND,
    input wire logic I_CASC_PREV,
    input wire logic I_CASC_NEXT,
    input wire gcm_pkg::gcm_ctrl_s I_CTRL,
    output logic O_CLK,
    output gcm_pkg::gcm_pass_s O_PASSING,
    output logic O_CFG_ERR
);
    localparam logic CFG_BAD = BOOT_PICK_FIRST & BOOT_PICK_SECOND;

    function automatic logic pick_src(input gcm_pkg::gcm_src_e src,
                                      input logic pin, input logic prv,
                                      input logic nxt);
        case (src)
            gcm_pkg::SRC_PREV: pick_src = prv;
            gcm_pkg::SRC_NEXT: pick_src = nxt;
            default: pick_src = pin;
        endcase
    endfunction

    function automatic gcm_pkg::gcm_tgt_e tgt_of(input gcm_pkg::gcm_state_e s);
        case (s)
            gcm_pkg::ST_RUN_FIRST, gcm_pkg::ST_WAIT_FIRST:
                tgt_of = gcm_pkg::TGT_FIRST;
            gcm_pkg::ST_RUN_SECOND, gcm_pkg::ST_WAIT_SECOND:
                tgt_of = gcm_pkg::TGT_SECOND;
            default: tgt_of = gcm_pkg::TGT_NONE;
        endcase
    endfunction

    logic raw_first;
    logic raw_second;
    logic [gcm_pkg::SYNC_W-1:0] sync_w;
    logic [gcm_pkg::CLK_W-1:0] clk_s;
    logic [gcm_pkg::CLK_W-1:0] clk_prev_q;
    gcm_pkg::gcm_ctrl_s ctrl_s;
    logic ok_first;
    logic ok_second;
    logic park_first;
    logic park_second;
    gcm_pkg::gcm_tgt_e want;
    gcm_pkg::gcm_state_e state_q;
    gcm_pkg::gcm_state_e state_d;
    gcm_pkg::gcm_state_e boot_state;
    logic clk_d;

    // input clocks may come from pins or from ring neighbours
    assign raw_first = pick_src(SRC_FIRST, I_CLK_IN_FIRST, I_CASC_PREV,
                                I_CASC_NEXT);
    assign raw_second = pick_src(SRC_SECOND, I_CLK_IN_SECOND, I_CASC_PREV,
                                 I_CASC_NEXT);

    // input clocks and requests pass two flops before any decision
    gcm_sync #(.W(gcm_pkg::SYNC_W)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_nrst(I_NRST),
        .i_async({I_CTRL, raw_second, raw_first}),
        .o_sync(sync_w)
    );

    assign clk_s = sync_w[gcm_pkg::CLK_W-1:0];
    assign ctrl_s = sync_w[gcm_pkg::SYNC_W-1:gcm_pkg::POS_CTRL_LO];

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            clk_prev_q <= gcm_pkg::CLK_W'(gcm_pkg::SYNC_RST);
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    // park edge: transition of an input clock into the idle level
    assign park_first = (clk_s[gcm_pkg::POS_CLK_FIRST] == INIT_OUT) &&
        (clk_prev_q[gcm_pkg::POS_CLK_FIRST] != INIT_OUT);
    assign park_second = (clk_s[gcm_pkg::POS_CLK_SECOND] == INIT_OUT) &&
        (clk_prev_q[gcm_pkg::POS_CLK_SECOND] != INIT_OUT);

    // variants reuse the core with lines tied
    always_comb begin
        case (MODE)
            gcm_pkg::MODE_GATE: begin
                ok_first = ctrl_s.enable_first;
                ok_second = gcm_pkg::OFF;
            end
            gcm_pkg::MODE_ONE_SEL: begin
                ok_first = ~ctrl_s.select_first;
                ok_second = ctrl_s.select_first;
            end
            default: begin
                ok_first = ctrl_s.select_first & ctrl_s.enable_first;
                ok_second = ctrl_s.select_second & ctrl_s.enable_second;
            end
        endcase
    end

    always_comb begin
        if (ok_first && !ok_second) begin
            want = gcm_pkg::TGT_FIRST;
        end else if (ok_second && !ok_first) begin
            want = gcm_pkg::TGT_SECOND;
        end else if (ok_first && ok_second) begin
            want = tgt_of(state_q);
        end else begin
            want = gcm_pkg::TGT_NONE;
        end
    end

    // with both boot picks set the configuration is refused: start idle
    always_comb begin
        if (CFG_BAD) begin
            boot_state = gcm_pkg::ST_IDLE;
        end else if (BOOT_PICK_FIRST) begin
            boot_state = gcm_pkg::ST_RUN_FIRST;
        end else if (BOOT_PICK_SECOND && MODE != gcm_pkg::MODE_GATE) begin
            boot_state = gcm_pkg::ST_RUN_SECOND;
        end else begin
            boot_state = gcm_pkg::ST_IDLE;
        end
    end

    function automatic gcm_pkg::gcm_state_e wait_for(input gcm_pkg::gcm_tgt_e t);
        case (t)
            gcm_pkg::TGT_FIRST: wait_for = gcm_pkg::ST_WAIT_FIRST;
            gcm_pkg::TGT_SECOND: wait_for = gcm_pkg::ST_WAIT_SECOND;
            default: wait_for = gcm_pkg::ST_IDLE;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        case (state_q)
            gcm_pkg::ST_RUN_FIRST: begin
                // a stopped clock never parks, hence the bypass
                if (want != gcm_pkg::TGT_FIRST &&
                    (park_first || ctrl_s.bypass_first)) begin
                    state_d = wait_for(want);
                end
            end
            gcm_pkg::ST_RUN_SECOND: begin
                if (want != gcm_pkg::TGT_SECOND &&
                    (park_second || ctrl_s.bypass_second)) begin
                    state_d = wait_for(want);
                end
            end
            gcm_pkg::ST_WAIT_FIRST: begin
                if (want != gcm_pkg::TGT_FIRST) begin
                    state_d = wait_for(want);
                end else if (park_first) begin
                    state_d = gcm_pkg::ST_RUN_FIRST;
                end
            end
            gcm_pkg::ST_WAIT_SECOND: begin
                if (want != gcm_pkg::TGT_SECOND) begin
                    state_d = wait_for(want);
                end else if (park_second) begin
                    state_d = gcm_pkg::ST_RUN_SECOND;
                end
            end
            default: begin
                state_d = wait_for(want);
            end
        endcase
    end

    // output follows the chosen synced clock, else holds the park level
    always_comb begin
        case (state_d)
            gcm_pkg::ST_RUN_FIRST: clk_d = clk_s[gcm_pkg::POS_CLK_FIRST];
            gcm_pkg::ST_RUN_SECOND: clk_d = clk_s[gcm_pkg::POS_CLK_SECOND];
            default: clk_d = INIT_OUT;
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            state_q <= boot_state;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_CLK <= INIT_OUT;
            O_PASSING <= gcm_pkg::PASS_RST;
            O_CFG_ERR <= CFG_BAD;
        end else begin
            O_CLK <= clk_d;
            O_PASSING.first <= (state_d == gcm_pkg::ST_RUN_FIRST);
            O_PASSING.second <= (state_d == gcm_pkg::ST_RUN_SECOND);
            O_CFG_ERR <= CFG_BAD;
        end
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);

    a_park_hold: assert property (
        state_q inside {gcm_pkg::ST_IDLE, gcm_pkg::ST_WAIT_FIRST,
                        gcm_pkg::ST_WAIT_SECOND} |-> O_CLK == INIT_OUT)
        else $error("output not parked while no clock passes");
    a_first_follows: assert property (
        state_q == gcm_pkg::ST_RUN_FIRST && $past(I_NRST) |->
        O_CLK == $past(clk_s[gcm_pkg::POS_CLK_FIRST]))
        else $error("output does not follow first clock");
    a_both_keep: assert property (
        ok_first && ok_second &&
        state_q inside {gcm_pkg::ST_RUN_FIRST, gcm_pkg::ST_RUN_SECOND} |=>
        state_q == $past(state_q))
        else $error("all lines high changed the choice");
    a_old_waits: assert property (
        state_q == gcm_pkg::ST_RUN_FIRST && !park_first &&
        !ctrl_s.bypass_first |=> state_q == gcm_pkg::ST_RUN_FIRST)
        else $error("left first clock before its park edge");
    a_bypass_leave: assert property (
        state_q == gcm_pkg::ST_RUN_SECOND && ctrl_s.bypass_second &&
        want != gcm_pkg::TGT_SECOND |=> state_q != gcm_pkg::ST_RUN_SECOND)
        else $error("bypass did not leave second clock at once");
    a_new_waits: assert property (
        state_q == gcm_pkg::ST_WAIT_SECOND && !park_second &&
        want == gcm_pkg::TGT_SECOND |=> state_q == gcm_pkg::ST_WAIT_SECOND)
        else $error("entered second clock before its park edge");
    a_new_taken: assert property (
        state_q == gcm_pkg::ST_WAIT_SECOND && park_second &&
        want == gcm_pkg::TGT_SECOND |=> O_PASSING.second ##1
        O_CLK == $past(clk_s[gcm_pkg::POS_CLK_SECOND]))
        else $error("second clock not passed after park edge");
    a_pair_needed: assert property (
        MODE == gcm_pkg::MODE_FULL && state_q == gcm_pkg::ST_IDLE &&
        !(ok_first ^ ok_second) |=> state_q == gcm_pkg::ST_IDLE)
        else $error("idle left without exactly one full pair");
    a_cfg_reject: assert property (
        O_CFG_ERR == CFG_BAD)
        else $error("configuration error flag wrong");
    a_gate_single: assert property (
        MODE == gcm_pkg::MODE_GATE |-> !O_PASSING.second)
        else $error("gate variant passed second input");

    c_switch_to_second: cover property (
        state_q == gcm_pkg::ST_RUN_FIRST ##[1:200]
        state_q == gcm_pkg::ST_RUN_SECOND);
    c_bypass_switch: cover property (
        state_q == gcm_pkg::ST_RUN_SECOND && ctrl_s.bypass_second ##1
        state_q == gcm_pkg::ST_WAIT_FIRST);
    c_park_idle: cover property (
        state_q == gcm_pkg::ST_RUN_FIRST ##1 state_q == gcm_pkg::ST_IDLE);
endmodule

// *** test/gcm_ctl_model.sv ***
// far-side model: two slow input clocks and the control lines
`timescale 1ns/1ps
module gcm_ctl_model #(
    parameter int HP1 = 4,
    parameter int HP2 = 7
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_req,
    input wire logic i_use_en,
    input wire logic i_stop_first,
    input wire logic [1:0] i_byp,
    output logic o_clk_first,
    output logic o_clk_second,
    output gcm_pkg::gcm_ctrl_s o_ctrl
);
    int cnt_a;
    int cnt_b;
    logic tgl_a;
    logic tgl_b;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_a <= 0;
            tgl_a <= 1'b0;
        end else if (cnt_a == HP1 - 1) begin
            cnt_a <= 0;
            tgl_a <= ~tgl_a;
        end else begin
            cnt_a <= cnt_a + 1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_b <= 0;
            tgl_b <= 1'b0;
        end else if (cnt_b == HP2 - 1) begin
            cnt_b <= 0;
            tgl_b <= ~tgl_b;
        end else begin
            cnt_b <= cnt_b + 1;
        end
    end

    // a stopped source sits low, like a dead oscillator
    assign o_clk_first = tgl_a & ~i_stop_first;
    assign o_clk_second = tgl_b;

    always_comb begin
        o_ctrl = 6'h3F; // spare line of each pair tied high
        if (i_use_en) begin
            o_ctrl.enable_first = i_req[0];
            o_ctrl.enable_second = i_req[1];
        end else begin
            o_ctrl.select_first = i_req[0];
            o_ctrl.select_second = i_req[1];
        end
        // all four high only when the bench asks for it
        o_ctrl.bypass_first = i_byp[0];
        o_ctrl.bypass_second = i_byp[1];
    end
endmodule

// *** test/gcm_dual_clock_glitchless_mux_tb_top.sv ***
// self-checking bench for the glitchless clock multiplexer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module gcm_dual_clock_glitchless_mux_tb_top;
    localparam int HP1 = 4;
    localparam int HP2 = 7;
    logic clk, nrst, use_en, stop_first, hold_chk, clk_a, clk_b;
    logic oclk0, oclk1, oclk2, err0, err1, err2;
    logic [1:0] req, byp, cur, prev_pass, exp_v;
    gcm_pkg::gcm_ctrl_s ctrl;
    gcm_pkg::gcm_pass_s pass0, pass1, pass2;
    logic [1:0] exp_q [$];
    logic [31:0] lfsr;
    int failures, checks;
    int run [2];
    logic lvl [2];

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    gcm_ctl_model #(.HP1(HP1), .HP2(HP2)) u_gcm_ctl_model (
        .i_clk(clk), .i_nrst(nrst), .i_req(req), .i_use_en(use_en),
        .i_stop_first(stop_first), .i_byp(byp), .o_clk_first(clk_a),
        .o_clk_second(clk_b), .o_ctrl(ctrl));
    gcm_dual_clock_glitchless_mux #(.BOOT_PICK_FIRST(gcm_pkg::ON))
    u_gcm_dual_clock_glitchless_mux (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_CLK_IN_FIRST(clk_a),
        .I_CLK_IN_SECOND(clk_b), .I_CASC_PREV(oclk1), .I_CASC_NEXT(oclk1),
        .I_CTRL(ctrl), .O_CLK(oclk0), .O_PASSING(pass0), .O_CFG_ERR(err0));
    // park-high twin with both boot picks, which must be refused
    gcm_dual_clock_glitchless_mux #(.INIT_OUT(1'b1),
        .BOOT_PICK_FIRST(gcm_pkg::ON), .BOOT_PICK_SECOND(gcm_pkg::ON))
    u_gcm_dual_clock_glitchless_mux_hi (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_CLK_IN_FIRST(clk_a),
        .I_CLK_IN_SECOND(clk_b), .I_CASC_PREV(oclk0), .I_CASC_NEXT(oclk0),
        .I_CTRL(ctrl), .O_CLK(oclk1), .O_PASSING(pass1), .O_CFG_ERR(err1));
    // gate variant: only the first input may ever pass
    gcm_dual_clock_glitchless_mux #(.MODE(gcm_pkg::MODE_GATE))
    u_gcm_dual_clock_glitchless_mux_gate (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_CLK_IN_FIRST(clk_a),
        .I_CLK_IN_SECOND(clk_b), .I_CASC_PREV(oclk0), .I_CASC_NEXT(oclk1),
        .I_CTRL(ctrl), .O_CLK(oclk2), .O_PASSING(pass2), .O_CFG_ERR(err2));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [1:0] code2pass(input logic [1:0] t);
        return (t == 2'h1) ? 2'h2 : ((t == 2'h2) ? 2'h1 : 2'h0);
    endfunction

    // active pulses keep the source width, park runs are never short
    function automatic void check_run(input int i, input logic o,
                                      input logic park);
        logic ok;
        ok = (lvl[i] === park) ? (run[i] >= HP1) :
            (run[i] == HP1 || run[i] == HP2);
        if (o !== lvl[i]) begin
            if (run[i] > 0) `CHK(ok, 1'b1)
            run[i] = hold_chk ? -100000 : 1;
            lvl[i] = o;
        end else begin
            run[i] = hold_chk ? -100000 : run[i] + 1;
        end
    endfunction

    task automatic request(input logic [1:0] t);
        if (t != 2'h3 && code2pass(t) !== cur) begin
            if (cur !== 2'h0) exp_q.push_back(2'h0);
            if (t != 2'h0) exp_q.push_back(code2pass(t));
            cur = code2pass(t);
        end
        @(posedge clk);
        req <= t;
    endtask

    task automatic settle;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        `CHK(exp_q.size(), 0)
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(negedge clk) begin
        if (nrst) begin
            if (pass0 !== prev_pass) begin
                if (exp_q.size() == 0) `CHK(pass0, prev_pass)
                else begin
                    exp_v = exp_q.pop_front();
                    `CHK(pass0, exp_v)
                end
            end
            prev_pass = pass0;
            if (pass0 === 2'h0) `CHK(oclk0, 1'b0)
            if (pass1 === 2'h0) `CHK(oclk1, 1'b1)
            if (pass2 === 2'h0) `CHK(oclk2, 1'b0)
            `CHK(pass2.second, 1'b0)
            check_run(0, oclk0, 1'b0);
            check_run(1, oclk1, 1'b1);
        end else begin
            prev_pass = 2'h0;
            run[0] = 0;
            run[1] = 0;
            lvl[0] = 1'b0;
            lvl[1] = 1'b1;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish;
    end

    initial begin
        nrst = 1'b0;
        req = 2'h1;
        use_en = 1'b0;
        stop_first = 1'b0;
        byp = 2'h0;
        hold_chk = 1'b0;
        failures = 0;
        checks = 0;
        lfsr = 32'h00012A62;
        cur = 2'h2;
        exp_q.push_back(2'h2);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        settle;
        @(negedge clk);
        `CHK(err0, 1'b0)
        `CHK(err1, 1'b1)
        `CHK(err2, 1'b0)
        request(2'h3);
        repeat (40) @(posedge clk);
        @(negedge clk);
        `CHK(pass0, 2'h2)
        `CHK(pass2, 2'h2)
        for (int k = 0; k < 16; k++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            use_en <= lfsr[5];
            request((lfsr[1:0] == 2'h3) ? 2'h1 : lfsr[1:0]);
            settle;
            repeat (lfsr[4:2]) @(posedge clk);
        end
        request(2'h1);
        settle;
        // dead first clock: no park edge ever comes without the bypass
        @(posedge clk);
        hold_chk <= 1'b1;
        stop_first <= 1'b1;
        request(2'h2);
        repeat (60) @(posedge clk);
        @(negedge clk);
        `CHK(pass0, 2'h2)
        @(posedge clk);
        byp <= 2'h1;
        settle;
        @(negedge clk);
        `CHK(pass0, 2'h1)
        // second bypass: leave the second clock as soon as asked
        @(posedge clk);
        stop_first <= 1'b0;
        byp <= 2'h2;
        request(2'h1);
        settle;
        @(negedge clk);
        `CHK(pass0, 2'h2)
        @(posedge clk);
        byp <= 2'h0;
        repeat (20) @(posedge clk);
        hold_chk <= 1'b0;
        request(2'h0);
        settle;
        repeat (30) @(posedge clk);
        tally_and_finish;
    end
endmodule
